// ---- bench/ssr_chk_sva.sv ----
/*
  Checker for the bus between the controller and memory ends.
  Assumes one clock and the interface signals handed in by name.
*/
`timescale 1ns/100ps
module ssr_chk
  import ssr_pkg::*;
#(
  parameter int POWER_CYCLES = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chip_enable_first_n,
  input wire logic chip_enable_second,
  input wire logic chip_enable_third_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic sleep_request,
  input wire logic host_dq_oe,
  input wire logic mem_dq_oe
);
  logic sel;
  logic rd_start;
  logic wr_cyc;
  int pcnt;
  assign sel = !chip_enable_first_n && chip_enable_second && !chip_enable_third_n;
  // Either full-width form counts as a write
  assign wr_cyc = !global_write_n || (!byte_write_gate_n && byte_lane_write_n == '0);
  assign rd_start = sel && !controller_addr_strobe_n && !wr_cyc;
  // Saturates so a long run cannot wrap it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pcnt <= 0;
    end else if (pcnt < POWER_CYCLES) begin
      pcnt <= pcnt + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_wr_sel; host_dq_oe |-> sel && !controller_addr_strobe_n; endproperty
  a_wr_sel: assert property (p_wr_sel)
    else $error("write data driven while deselected");
  property p_full_wr; wr_cyc |-> host_dq_oe && sel; endproperty
  a_full_wr: assert property (p_full_wr)
    else $error("full write without selected data cycle");
  property p_wr_hiz; wr_cyc |=> !mem_dq_oe [*2]; endproperty
  a_wr_hiz: assert property (p_wr_hiz)
    else $error("read data driven after write");
  property p_rd_oe; $rose(mem_dq_oe) |-> $past(rd_start, 2); endproperty
  a_rd_oe: assert property (p_rd_oe)
    else $error("read data driven without a read strobe");
  property p_sleep_in; $rose(sleep_request) |-> !$past(sel) && !sel; endproperty
  a_sleep_in: assert property (p_sleep_in)
    else $error("sleep requested while selected");
  property p_sleep_quiet;
    sleep_request |-> controller_addr_strobe_n && processor_addr_strobe_n && !sel;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("access during sleep");
  property p_wake_hiz; $fell(sleep_request) |-> !mem_dq_oe [*2]; endproperty
  a_wake_hiz: assert property (p_wake_hiz)
    else $error("data lines driven on leaving sleep");
  property p_power;
    !(controller_addr_strobe_n && processor_addr_strobe_n) |-> pcnt == POWER_CYCLES;
  endproperty
  a_power: assert property (p_power)
    else $error("access before power wait ended");
endmodule

// ---- bench/sync_sram_access_rules_tb.sv ----
/*
  Testbench joining controller and memory ends through the bus interface.
  Assumes a shortened power wait; all stimulus on the falling edge.
*/
`timescale 1ns/100ps
module sync_sram_access_rules_tb
  import ssr_pkg::*;
;
  localparam int PWR = 40;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [ADDR_W-1:0] cmd_addr = 10'h000;
  logic [DATA_W-1:0] cmd_wdata = 32'h0;
  logic cmd_ready, rd_valid, powered, selected, asleep;
  logic [DATA_W-1:0] rd_data;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  ssr_bus_if ssr_bus_if_inst ();
  ssr_ctrl #(.POWER_CYCLES(PWR)) ssr_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .powered(powered),
    .bus(ssr_bus_if_inst.ctrl));
  ssr_mem ssr_mem_inst (.mclk(mclk), .sys_rst(sys_rst), .selected(selected),
    .asleep(asleep), .bus(ssr_bus_if_inst.mem));
  ssr_chk #(.POWER_CYCLES(PWR)) ssr_chk_inst (.mclk(mclk), .sys_rst(sys_rst),
    .chip_enable_first_n(ssr_bus_if_inst.chip_enable_first_n),
    .chip_enable_second(ssr_bus_if_inst.chip_enable_second),
    .chip_enable_third_n(ssr_bus_if_inst.chip_enable_third_n),
    .global_write_n(ssr_bus_if_inst.global_write_n),
    .byte_write_gate_n(ssr_bus_if_inst.byte_write_gate_n),
    .byte_lane_write_n(ssr_bus_if_inst.byte_lane_write_n),
    .processor_addr_strobe_n(ssr_bus_if_inst.processor_addr_strobe_n),
    .controller_addr_strobe_n(ssr_bus_if_inst.controller_addr_strobe_n),
    .sleep_request(ssr_bus_if_inst.sleep_request),
    .host_dq_oe(ssr_bus_if_inst.host_dq_oe), .mem_dq_oe(ssr_bus_if_inst.mem_dq_oe));
  always #25 mclk = ~mclk;
  // Whole run needs under 200 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  // Holds the request until the edge that accepts it
  task automatic push(input logic [1:0] op, input int a, input logic [DATA_W-1:0] d);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a[ADDR_W-1:0];
    cmd_wdata = d;
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask
  task automatic idle();
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask
  task automatic rd_check(input int a, input logic [DATA_W-1:0] exp);
    int i;
    push(OP_READ, a, 32'h0);
    idle();
    for (i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge mclk);
    check({31'h0, rd_valid}, 32'h1, "no read answer");
    check(rd_data, exp, "read data");
  endtask
  task automatic t_power_fill();
    for (int i = 0; i < FIFO_DEPTH; i++) push(OP_WRITE, i, 32'hc0de0000 | 32'(i));
    idle();
    check({31'h0, cmd_ready}, 32'h0, "queue not full");
    check({31'h0, powered}, 32'h0, "powered too early");
    for (int i = 0; i < 2 * PWR && powered !== 1'b1; i++) @(negedge mclk);
    check({31'h0, powered}, 32'h1, "power wait stuck");
    $display("power and fill test done");
  endtask
  task automatic t_readback();
    for (int i = 0; i < FIFO_DEPTH; i++) rd_check(i, 32'hc0de0000 | 32'(i));
    $display("readback test done");
  endtask
  task automatic t_sleep();
    push(OP_SLEEP, 0, 32'h0);
    idle();
    repeat (6) @(negedge mclk);
    check({31'h0, asleep}, 32'h1, "not asleep");
    check({31'h0, selected}, 32'h0, "selected in sleep");
    push(OP_WAKE, 0, 32'h0);
    idle();
    repeat (6) @(negedge mclk);
    check({31'h0, asleep}, 32'h0, "still asleep");
    push(OP_WRITE, 9, 32'h5a5a1234);
    rd_check(9, 32'h5a5a1234);
    $display("sleep test done");
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    t_power_fill();
    t_readback();
    t_sleep();
    report_and_stop();
  end
endmodule

// ---- src/ssr_bus_if.sv ----
/*
  Synchronous SRAM bus between controller and memory.
  Each data direction has its own lines and its own drive enable.
*/
`timescale 1ns/100ps
interface ssr_bus_if
  import ssr_pkg::*;
();
  logic chip_enable_first_n;
  logic chip_enable_second;
  logic chip_enable_third_n;
  logic global_write_n;
  logic byte_write_gate_n;
  logic [LANES-1:0] byte_lane_write_n;
  logic processor_addr_strobe_n;
  logic controller_addr_strobe_n;
  logic sleep_request;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_dq;
  logic host_dq_oe;
  logic [DATA_W-1:0] mem_dq;
  logic mem_dq_oe;
  modport ctrl (
    output chip_enable_first_n, chip_enable_second, chip_enable_third_n,
    output global_write_n, byte_write_gate_n, byte_lane_write_n,
    output processor_addr_strobe_n, controller_addr_strobe_n, sleep_request,
    output addr, host_dq, host_dq_oe,
    input mem_dq, mem_dq_oe
  );
  modport mem (
    input chip_enable_first_n, chip_enable_second, chip_enable_third_n,
    input global_write_n, byte_write_gate_n, byte_lane_write_n,
    input processor_addr_strobe_n, controller_addr_strobe_n, sleep_request,
    input addr, host_dq, host_dq_oe,
    output mem_dq, mem_dq_oe
  );
endinterface

// ---- src/ssr_ctrl.sv ----
/*
  Controller end: queues read/write/sleep commands through a FIFO and
  drives the synchronous SRAM bus. Assumes the memory end shares mclk.
*/
`timescale 1ns/100ps
// Function
// - Select only with enables low, high, low
// - Full write: global low, or gate+lanes low
// - Read data high-Z after write until strobe
// - Deselect the device before requesting sleep
// - Data lines high-Z on leaving sleep
// - Wait 1 ms after power before access
module ssr_ctrl
  import ssr_pkg::*;
#(
  parameter int POWER_CYCLES = POWER_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic powered,
  ssr_bus_if.ctrl bus
);
  if (POWER_CYCLES < 1) begin : g_bad_power
    $error("POWER_CYCLES must be at least 1");
  end
  logic q_valid;
  logic q_ready;
  logic [CMD_W-1:0] q_data;
  logic [1:0] q_op;
  ssr_host_state_e state;
  logic [31:0] pwr_cnt;
  logic [1:0] rd_wait;
  logic issue;
  logic issue_wr;
  logic lane_form;
  // Only reads and writes start bus cycles; sleep and wake only move the sleep request line
  function automatic logic is_access(input logic [1:0] op);
    is_access = op == OP_READ || op == OP_WRITE;
  endfunction
  assign q_op = q_data[CMD_W-1 -: 2];
  // One bus cycle for each read or write popped from the queue
  assign issue = state == SSR_IDLE && q_ready && is_access(q_op);
  assign issue_wr = issue && q_op == OP_WRITE;
  // Odd addresses use the byte gate form, so both full-width forms are used
  assign lane_form = q_data[DATA_W];
  ssr_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_op, cmd_addr, cmd_wdata}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );
  // Commands are only consumed from idle or sleep; sleep state consumes wake only
  assign q_ready = q_valid && ((state == SSR_IDLE && q_op != OP_WAKE)
    || (state == SSR_SLEEP && q_op == OP_WAKE) || (state == SSR_IDLE && q_op == OP_WAKE));
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_cnt <= '0;
    end else if (pwr_cnt != POWER_CYCLES) begin
      pwr_cnt <= pwr_cnt + 32'h1;
    end
  end
  assign powered = state != SSR_POWER;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SSR_POWER;
    end else begin
      case (state)
        SSR_POWER: begin
          if (pwr_cnt == POWER_CYCLES) begin
            state <= SSR_IDLE;
          end
        end
        SSR_IDLE: begin
          if (q_valid && q_op == OP_SLEEP) begin
            state <= SSR_DESEL;
          end else if (q_valid && q_op == OP_READ) begin
            state <= SSR_READ_WAIT;
          end
        end
        SSR_DESEL: begin
          state <= SSR_SLEEP;
        end
        SSR_SLEEP: begin
          if (q_valid && q_op == OP_WAKE) begin
            state <= SSR_IDLE;
          end
        end
        SSR_READ_WAIT: begin
          if (rd_wait == 2'h0) begin
            state <= SSR_IDLE;
          end
        end
        default: begin
          state <= SSR_IDLE;
        end
      endcase
    end
  end
  // Memory drives two edges after the strobe edge; the answer is taken one edge later
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_wait <= 2'h0;
    end else if (state == SSR_IDLE && q_ready && q_op == OP_READ) begin
      rd_wait <= READ_LATENCY_WAIT;
    end else if (rd_wait != 2'h0) begin
      rd_wait <= rd_wait - 2'h1;
    end
  end
  // Bus outputs registered so the memory sees them at the next rising edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.chip_enable_first_n <= 1'b1;
      bus.chip_enable_second <= 1'b0;
      bus.chip_enable_third_n <= 1'b1;
    end else if (issue) begin
      bus.chip_enable_first_n <= 1'b0;
      bus.chip_enable_second <= 1'b1;
      bus.chip_enable_third_n <= 1'b0;
    end else begin
      bus.chip_enable_first_n <= 1'b1;
      bus.chip_enable_second <= 1'b0;
      bus.chip_enable_third_n <= 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.global_write_n <= 1'b1;
    end else begin
      bus.global_write_n <= !(issue_wr && !lane_form);
    end
  end
  // Full width through the gate needs every lane control low as well
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.byte_write_gate_n <= 1'b1;
      bus.byte_lane_write_n <= '1;
    end else if (issue_wr && lane_form) begin
      bus.byte_write_gate_n <= 1'b0;
      bus.byte_lane_write_n <= '0;
    end else begin
      bus.byte_write_gate_n <= 1'b1;
      bus.byte_lane_write_n <= '1;
    end
  end
  // Processor strobe stays idle; this end only issues controller cycles
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.processor_addr_strobe_n <= 1'b1;
      bus.controller_addr_strobe_n <= 1'b1;
    end else begin
      bus.processor_addr_strobe_n <= 1'b1;
      bus.controller_addr_strobe_n <= !issue;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.addr <= '0;
    end else if (issue) begin
      bus.addr <= q_data[DATA_W +: ADDR_W];
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.host_dq <= '0;
      bus.host_dq_oe <= 1'b0;
    end else begin
      bus.host_dq_oe <= issue_wr;
      if (issue_wr) begin
        bus.host_dq <= q_data[DATA_W-1:0];
      end
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.sleep_request <= 1'b0;
    end else if (state == SSR_DESEL) begin
      bus.sleep_request <= 1'b1;
    end else if (state == SSR_SLEEP && q_ready) begin
      bus.sleep_request <= 1'b0;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= state == SSR_READ_WAIT && rd_wait == 2'h0 && bus.mem_dq_oe;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (state == SSR_READ_WAIT && rd_wait == 2'h0) begin
      rd_data <= bus.mem_dq;
    end
  end
endmodule

// ---- src/ssr_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] fill;
  assign fill = wr_ptr - rd_ptr;
  assign in_ready = fill != DEPTH[AW:0];
  assign out_valid = fill != '0;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ---- src/ssr_mem.sv ----
/*
  Memory end: small pipelined synchronous SRAM model in logic.
  Assumes the controller drives all inputs from the same rising edge.
*/
`timescale 1ns/100ps
module ssr_mem
  import ssr_pkg::*;
#(
  parameter int WORDS = 1 << ADDR_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic selected,
  output logic asleep,
  ssr_bus_if.mem bus
);
  if (WORDS < 1 || WORDS > (1 << ADDR_W) || DATA_W != 8 * LANES) begin : g_bad_size
    $error("WORDS out of range or lanes not bytes");
  end
  wire [DATA_W-1:0] rd_word;
  logic sel;
  logic strobe;
  logic full_wr;
  logic [LANES-1:0] lane_wr;
  logic rd_pend;
  logic [ADDR_W-1:0] rd_addr;
  function automatic logic is_selected(input logic c1_n, input logic c2,
      input logic c3_n);
    is_selected = !c1_n && c2 && !c3_n;
  endfunction
  assign sel = is_selected(bus.chip_enable_first_n, bus.chip_enable_second,
    bus.chip_enable_third_n);
  assign strobe = !bus.processor_addr_strobe_n || !bus.controller_addr_strobe_n;
  assign full_wr = !bus.global_write_n
    || (!bus.byte_write_gate_n && bus.byte_lane_write_n == '0);
  // Partial writes follow the lane controls while the gate is low
  assign lane_wr = full_wr ? '1 : (bus.byte_write_gate_n ? '0 : ~bus.byte_lane_write_n);
  assign selected = sel;
  // Sleep pin taken on the edge too, so all inputs share one timing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      asleep <= 1'b0;
    end else begin
      asleep <= bus.sleep_request;
    end
  end
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // One array per lane, so each array has a single writing process
      logic [7:0] lane_mem [WORDS];
      always_ff @(posedge mclk) begin
        if (!asleep && sel && strobe && lane_wr[g] && bus.addr < WORDS) begin
          lane_mem[bus.addr] <= bus.host_dq[g*8 +: 8];
        end
      end
      assign rd_word[g*8 +: 8] = lane_mem[rd_addr];
    end
  endgenerate
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_pend <= !asleep && !bus.sleep_request && sel && strobe && lane_wr == '0;
      rd_addr <= bus.addr;
    end
  end
  // Output drive only on the second cycle after a read strobe, never after a write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.mem_dq_oe <= 1'b0;
      bus.mem_dq <= '0;
    end else if (asleep || bus.sleep_request) begin
      bus.mem_dq_oe <= 1'b0;
    end else if (rd_pend) begin
      bus.mem_dq_oe <= 1'b1;
      bus.mem_dq <= (rd_addr < WORDS) ? rd_word : '0;
    end else begin
      bus.mem_dq_oe <= 1'b0;
    end
  end
endmodule

// ---- src/ssr_pkg.sv ----
/*
  Shared constants and types for the synchronous SRAM access pair.
  Assumes one 20 MHz clock shared by both ends.
*/
package ssr_pkg;
  localparam int CLK_PERIOD_PS = 50000;
  localparam int POWER_WAIT_MS = 1;
  // Least time rounds up to whole cycles
  localparam int POWER_WAIT_CYC =
    (POWER_WAIT_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int LANES = 4;
  localparam int FIFO_DEPTH = 8;
  // Edges left after the strobe edge before the read answer is sampled
  localparam logic [1:0] READ_LATENCY_WAIT = 2'h2;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SLEEP = 2'h2;
  localparam logic [1:0] OP_WAKE = 2'h3;
  localparam int CMD_W = 2 + ADDR_W + DATA_W;
  typedef enum logic [2:0] {
    SSR_POWER, SSR_IDLE, SSR_DESEL, SSR_SLEEP, SSR_READ_WAIT
  } ssr_host_state_e;
endpackage
